// File: core/dctu_pkg.sv
/*
 * Shared constants for the dual counter/timer and serial port block:
 * register offsets, field positions, reset values, mode codes and timing.
 * Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package dctu_pkg;
  localparam int ADDR_W = 5;
  localparam int CLK_HZ = 10_000_000;
  localparam int INT_DIV = 4;
  localparam int DIV_W = $clog2(INT_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INT_DIV - 1);
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] SUB_LAST = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] SUB_MID = 4'(OVERSAMPLE / 2 - 1);
  localparam int FRAME_BITS = 11;
  localparam logic [3:0] FRAME_LAST = 4'(FRAME_BITS - 1);
  localparam logic [3:0] DATA_LAST = 4'h7;

  localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_MODE = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_FIRST_CNT = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_FIRST_PRE = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_SECOND_CNT = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_SECOND_PRE = 5'h14;
  localparam logic [ADDR_W-1:0] OFF_SER_DATA = 5'h18;
  localparam logic [ADDR_W-1:0] OFF_SER_STAT = 5'h1c;

  // Control register: run, continuous and restart bits per timer.
  localparam int CTRL_FIRST_RUN = 0;
  localparam int CTRL_FIRST_CONT = 1;
  localparam int CTRL_FIRST_RESTART = 2;
  localparam int CTRL_SECOND_RUN = 3;
  localparam int CTRL_SECOND_CONT = 4;
  localparam int CTRL_SECOND_RESTART = 5;

  localparam int MODE_IN_LSB = 0;
  localparam int MODE_OUT_LSB = 2;
  localparam int MODE_CASCADE = 4;
  localparam int MODE_SER_EN = 5;
  localparam int MODE_PAR_EN = 6;

  localparam int STAT_TX_BUSY = 0;
  localparam int STAT_RX_FULL = 1;
  localparam int STAT_RX_BUSY = 2;
  localparam int STAT_FIRST_ACT = 3;
  localparam int STAT_SECOND_ACT = 4;

  localparam logic [1:0] IN_EXT_CLK = 2'h0;
  localparam logic [1:0] IN_GATE = 2'h1;
  localparam logic [1:0] IN_TRIG_ONCE = 2'h2;
  localparam logic [1:0] IN_TRIG_RETRIG = 2'h3;
  localparam logic [1:0] OUT_FIRST = 2'h0;
  localparam logic [1:0] OUT_SECOND = 2'h1;
  localparam logic [1:0] OUT_CLOCK = 2'h2;
  localparam logic [1:0] OUT_OFF = 2'h3;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] LOAD_RST = 8'h00;
  localparam logic [5:0] PRE_RST = 6'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} dctu_rx_state_t;
endpackage

// File: core/dctu_timer.sv
/*
 * One prescaler plus down-counter.
 * Assumes tick is a one-cycle enable from the selected source clock.
 */
module dctu_timer #(
  parameter int PRE_W = 6,
  parameter int CNT_W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic tick,
  input wire logic run,
  input wire logic restart,
  input wire logic cont,
  input wire logic [PRE_W-1:0] preLoad,
  input wire logic [CNT_W-1:0] cntLoad,
  // Status
  output logic [CNT_W-1:0] count,
  output logic endPulse,
  output logic active
);
  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [CNT_W-1:0] cnt;
    logic act;
    logic endP;
  } dctu_timer_state_t;

  dctu_timer_state_t s_r, s_nxt;

  // A load of zero wraps through the full range, giving 64 and 256.
  always_comb begin
    s_nxt = s_r;
    s_nxt.endP = 1'b0;
    if (restart) begin
      s_nxt.pre = preLoad; // R6
      s_nxt.cnt = cntLoad;
      s_nxt.act = 1'b1;
    end else if (s_r.act && run && tick) begin
      if (s_r.pre == PRE_W'(1)) begin
        s_nxt.pre = preLoad; // R3
        if (s_r.cnt == CNT_W'(1)) begin
          s_nxt.endP = 1'b1; // R5
          if (cont) begin
            s_nxt.cnt = cntLoad; // R7
          end else begin
            s_nxt.cnt = '0;
            s_nxt.act = 1'b0;
          end
        end else begin
          s_nxt.cnt = s_r.cnt - CNT_W'(1); // R4
        end
      end else begin
        s_nxt.pre = s_r.pre - PRE_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign count = s_r.cnt;
  assign endPulse = s_r.endP;
  assign active = s_r.act;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_reload;
    endPulse && $past(cont) && !$past(restart) |-> count == $past(cntLoad);
  endproperty
  a_reload: assert property (p_reload) else $error("continuous reload missed"); // R7

  property p_single;
    endPulse && !$past(cont) |-> !active && count == '0;
  endproperty
  a_single: assert property (p_single) else $error("single pass did not halt"); // R7

  property p_decrement;
    active && run && tick && !restart && s_r.pre == PRE_W'(1) && count != CNT_W'(1)
      |=> count == $past(count) - CNT_W'(1);
  endproperty
  a_decrement: assert property (p_decrement) else $error("counter did not decrement"); // R4
endmodule

// File: core/dctu_top.sv
/*
 * Dual 8-bit counter/timer with prescalers and a full-duplex serial port,
 * reached over AXI4-Lite. Assumes pins are synchronous to clk_sys and that
 * an outside interrupt controller takes the request pulses.
 */
// Contract
// R1 - Two independent 8-bit counters, each clocked by its own 6-bit prescaler.
// R2 - First prescaler uses internal clock only; second takes internal or external.
// R3 - Each prescaler divides its source by any ratio from 1 to 64.
// R4 - Counter decrements per prescaler pulse from a loaded value of 1 to 256.
// R5 - Prescaler and counter ending together raise that timer's request.
// R6 - Software can start, stop, resume or restart each counter.
// R7 - Single pass halts at zero; continuous mode reloads and keeps counting.
// R8 - Counters read without disturbance; prescalers are not readable.
// R9 - Second timer source is internal clock over four or the input pin.
// R10 - Input pin is external clock, retriggerable or one-shot trigger, or gate.
// R11 - Output pin carries first timer, second timer or internal clock.
// R12 - Timers cascade with first timer output feeding the second timer.
// R13 - Serial mode uses the receive input and transmit output lines together.
// R14 - Serial bit timing comes from the first timer period.
// R15 - Transmitter sends start bit, eight data bits, then two stop bits.
// R16 - With parity on, eighth bit sent is odd parity of seven bits.
// R17 - Every transmitted character raises the transmit/first-timer request.
// R18 - Remote sender frames with start, eight data, at least one stop.
// R19 - With parity on, received bit 7 becomes the parity error flag.
// R20 - Each received character raises the receive request, shared with the pin.
// R21 - All four input lines can raise external interrupt requests.
// R22 - Timers and external interrupt inputs keep working during halt.
// R23 - Transmit line idles high; receiver starts on a falling edge.
module dctu_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [dctu_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dctu_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Port lines
  input wire logic serialInLine,
  input wire logic timerInPin,
  input wire logic extLineA,
  input wire logic extLineB,
  output logic serialOutLine,
  output logic timerOutPin,
  // Interrupt requests
  output logic serialRxInterrupt,
  output logic serialTxOrFirstTimerInterrupt,
  output logic secondTimerInterrupt,
  output logic extInterruptA,
  output logic extInterruptB,
  output logic extInterruptC
);
  typedef struct packed {
    logic [dctu_pkg::DIV_W-1:0] div;
    logic divTick;
    logic run0, cont0, run1, cont1, restart0, restart1;
    logic [1:0] inMode, outSel;
    logic cascade, serEn, parEn;
    logic [7:0] load0, load1;
    logic [5:0] pre0, pre1;
    logic tinPrev, serPrev, aPrev, bPrev;
    logic tog0, tog1, clkTog, tout;
    logic rxInt, txInt, t1Int, extA, extB, extC;
    logic awReady, awHeld, wReady, wHeld, bValid, arReady, rValid;
    logic [dctu_pkg::ADDR_W-1:0] awAddr;
    logic [7:0] wData;
    logic wLane;
    logic [1:0] bResp, rResp;
    logic [31:0] rData;
    logic txBusy, txLine;
    logic [10:0] txShift;
    logic [3:0] txSub, txBits;
    dctu_pkg::dctu_rx_state_t rxSt;
    logic [3:0] rxSub, rxBits;
    logic [7:0] rxShift, rxData;
    logic rxFull;
  } dctu_top_state_t;

  dctu_top_state_t s_r, s_nxt;

  logic [1:0] tmTick, tmRun, tmRestart, tmCont, tmEnd, tmAct;
  logic [1:0][5:0] tmPre;
  logic [1:0][7:0] tmLoad, tmCount;
  logic tinRise, tinFall, serFall, trigger;
  logic [dctu_pkg::ADDR_W-1:0] wrAddr, rdAddr;

  assign tinRise = !s_r.tinPrev && timerInPin;
  assign tinFall = s_r.tinPrev && !timerInPin;
  assign serFall = s_r.serPrev && !serialInLine;
  assign wrAddr = {s_r.awAddr[dctu_pkg::ADDR_W-1:2], 2'h0};
  assign rdAddr = {s_axi_araddr[dctu_pkg::ADDR_W-1:2], 2'h0};

  // A retriggerable trigger always restarts; the one-shot kind waits for expiry.
  assign trigger = tinRise && ((s_r.inMode == dctu_pkg::IN_TRIG_RETRIG) || // R10
    (s_r.inMode == dctu_pkg::IN_TRIG_ONCE && !tmAct[1]));

  // The divider never stops, so the timers keep running in halt.
  assign tmTick[0] = s_r.divTick; // R2 R22
  assign tmTick[1] = s_r.cascade ? tmEnd[0] : // R12
    (s_r.inMode == dctu_pkg::IN_EXT_CLK) ? tinRise : // R9
    (s_r.inMode == dctu_pkg::IN_GATE) ? (s_r.divTick && timerInPin) : s_r.divTick; // R10
  assign tmRun = {s_r.run1, s_r.run0};
  assign tmCont = {s_r.cont1, s_r.cont0};
  assign tmRestart = {s_r.restart1 || trigger, s_r.restart0};
  assign tmPre = {s_r.pre1, s_r.pre0};
  assign tmLoad = {s_r.load1, s_r.load0};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_timer
      dctu_timer #(.PRE_W(6), .CNT_W(8)) u_timer ( // R1
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(tmTick[gi]),
        .run(tmRun[gi]),
        .restart(tmRestart[gi]),
        .cont(tmCont[gi]),
        .preLoad(tmPre[gi]),
        .cntLoad(tmLoad[gi]),
        .count(tmCount[gi]),
        .endPulse(tmEnd[gi]),
        .active(tmAct[gi])
      );
    end
  endgenerate

  always_comb begin
    logic txStart;
    logic txDone;
    logic rxDone;
    txStart = 1'b0;
    txDone = 1'b0;
    rxDone = 1'b0;
    s_nxt = s_r;
    s_nxt.restart0 = 1'b0;
    s_nxt.restart1 = 1'b0;
    s_nxt.divTick = (s_r.div == dctu_pkg::DIV_LAST);
    s_nxt.div = s_nxt.divTick ? '0 : s_r.div + dctu_pkg::DIV_W'(1);
    s_nxt.tinPrev = timerInPin;
    s_nxt.serPrev = serialInLine;
    s_nxt.aPrev = extLineA;
    s_nxt.bPrev = extLineB;
    s_nxt.extA = s_r.aPrev && !extLineA; // R21 R22
    s_nxt.extB = s_r.bPrev && !extLineB; // R21
    s_nxt.extC = tinFall; // R21
    s_nxt.t1Int = tmEnd[1]; // R5

    if (tmEnd[0]) s_nxt.tog0 = !s_r.tog0;
    if (tmEnd[1]) s_nxt.tog1 = !s_r.tog1;
    if (s_r.divTick) s_nxt.clkTog = !s_r.clkTog;
    unique case (s_r.outSel) // R11
      dctu_pkg::OUT_FIRST: s_nxt.tout = s_nxt.tog0;
      dctu_pkg::OUT_SECOND: s_nxt.tout = s_nxt.tog1;
      dctu_pkg::OUT_CLOCK: s_nxt.tout = s_nxt.clkTog;
      dctu_pkg::OUT_OFF: s_nxt.tout = 1'b1;
    endcase

    // Write channel: address and data are held separately, then applied together.
    if (s_axi_awvalid && s_r.awReady) begin
      s_nxt.awHeld = 1'b1;
      s_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wReady) begin
      s_nxt.wHeld = 1'b1;
      s_nxt.wData = s_axi_wdata[7:0];
      s_nxt.wLane = s_axi_wstrb[0];
    end
    if (s_r.bValid && s_axi_bready) s_nxt.bValid = 1'b0;
    if (s_r.awHeld && s_r.wHeld && !s_r.bValid) begin
      s_nxt.awHeld = 1'b0;
      s_nxt.wHeld = 1'b0;
      s_nxt.bValid = 1'b1;
      s_nxt.bResp = dctu_pkg::RESP_OKAY;
      unique case (wrAddr)
        dctu_pkg::OFF_CTRL: if (s_r.wLane) begin
          s_nxt.run0 = s_r.wData[dctu_pkg::CTRL_FIRST_RUN]; // R6
          s_nxt.cont0 = s_r.wData[dctu_pkg::CTRL_FIRST_CONT];
          s_nxt.restart0 = s_r.wData[dctu_pkg::CTRL_FIRST_RESTART]; // R6
          s_nxt.run1 = s_r.wData[dctu_pkg::CTRL_SECOND_RUN];
          s_nxt.cont1 = s_r.wData[dctu_pkg::CTRL_SECOND_CONT];
          s_nxt.restart1 = s_r.wData[dctu_pkg::CTRL_SECOND_RESTART];
        end
        dctu_pkg::OFF_MODE: if (s_r.wLane) begin
          s_nxt.inMode = s_r.wData[dctu_pkg::MODE_IN_LSB +: 2];
          s_nxt.outSel = s_r.wData[dctu_pkg::MODE_OUT_LSB +: 2];
          s_nxt.cascade = s_r.wData[dctu_pkg::MODE_CASCADE];
          s_nxt.serEn = s_r.wData[dctu_pkg::MODE_SER_EN]; // R13
          s_nxt.parEn = s_r.wData[dctu_pkg::MODE_PAR_EN];
        end
        dctu_pkg::OFF_FIRST_CNT: if (s_r.wLane) s_nxt.load0 = s_r.wData;
        dctu_pkg::OFF_FIRST_PRE: if (s_r.wLane) s_nxt.pre0 = s_r.wData[5:0];
        dctu_pkg::OFF_SECOND_CNT: if (s_r.wLane) s_nxt.load1 = s_r.wData;
        dctu_pkg::OFF_SECOND_PRE: if (s_r.wLane) s_nxt.pre1 = s_r.wData[5:0];
        dctu_pkg::OFF_SER_DATA: txStart = s_r.wLane && s_r.serEn && !s_r.txBusy;
        dctu_pkg::OFF_SER_STAT: s_nxt.bResp = dctu_pkg::RESP_OKAY;
        default: s_nxt.bResp = dctu_pkg::RESP_SLVERR;
      endcase
    end
    s_nxt.awReady = !s_nxt.awHeld && !s_nxt.bValid;
    s_nxt.wReady = !s_nxt.wHeld && !s_nxt.bValid;

    // Read channel: one outstanding read, answered the cycle after acceptance.
    if (s_r.rValid && s_axi_rready) s_nxt.rValid = 1'b0;
    if (s_axi_arvalid && s_r.arReady) begin
      s_nxt.rValid = 1'b1;
      s_nxt.rResp = dctu_pkg::RESP_OKAY;
      s_nxt.rData = '0;
      unique case (rdAddr)
        dctu_pkg::OFF_CTRL: s_nxt.rData[5:0] = {1'b0, s_r.cont1, s_r.run1, 1'b0, s_r.cont0, s_r.run0};
        dctu_pkg::OFF_MODE: s_nxt.rData[6:0] = {s_r.parEn, s_r.serEn, s_r.cascade, s_r.outSel, s_r.inMode};
        dctu_pkg::OFF_FIRST_CNT: s_nxt.rData[7:0] = tmCount[0]; // R8
        dctu_pkg::OFF_SECOND_CNT: s_nxt.rData[7:0] = tmCount[1]; // R8
        dctu_pkg::OFF_FIRST_PRE, dctu_pkg::OFF_SECOND_PRE: s_nxt.rData = '0; // R8
        dctu_pkg::OFF_SER_DATA: begin
          s_nxt.rData[7:0] = s_r.rxData;
          s_nxt.rxFull = 1'b0;
        end
        dctu_pkg::OFF_SER_STAT: begin
          s_nxt.rData[dctu_pkg::STAT_TX_BUSY] = s_r.txBusy;
          s_nxt.rData[dctu_pkg::STAT_RX_FULL] = s_r.rxFull;
          s_nxt.rData[dctu_pkg::STAT_RX_BUSY] = (s_r.rxSt != dctu_pkg::RX_IDLE);
          s_nxt.rData[dctu_pkg::STAT_FIRST_ACT] = tmAct[0];
          s_nxt.rData[dctu_pkg::STAT_SECOND_ACT] = tmAct[1];
        end
        default: s_nxt.rResp = dctu_pkg::RESP_SLVERR;
      endcase
    end
    s_nxt.arReady = !s_nxt.rValid;

    // Transmitter: one bit per sixteen first-timer expiries.
    if (txStart) begin
      s_nxt.txShift = {2'b11, s_r.parEn ? ~^s_r.wData[6:0] : s_r.wData[7], s_r.wData[6:0], 1'b0}; // R15 R16
      s_nxt.txBusy = 1'b1;
      s_nxt.txSub = '0;
      s_nxt.txBits = '0;
      s_nxt.txLine = 1'b0;
    end else if (s_r.txBusy && tmEnd[0]) begin // R14
      s_nxt.txSub = s_r.txSub + 4'h1;
      if (s_r.txSub == dctu_pkg::SUB_LAST) begin
        s_nxt.txShift = {1'b1, s_r.txShift[10:1]};
        s_nxt.txLine = s_r.txShift[1];
        s_nxt.txBits = s_r.txBits + 4'h1;
        if (s_r.txBits == dctu_pkg::FRAME_LAST) begin
          s_nxt.txBusy = 1'b0;
          s_nxt.txLine = 1'b1; // R23
          txDone = 1'b1;
        end
      end
    end
    s_nxt.txInt = tmEnd[0] || txDone; // R5 R17

    // Receiver: samples mid-bit; a stop bit sampled low is not flagged.
    if (tmEnd[0] && s_r.rxSt != dctu_pkg::RX_IDLE) s_nxt.rxSub = s_r.rxSub + 4'h1;
    unique case (s_r.rxSt)
      dctu_pkg::RX_IDLE: if (s_r.serEn && serFall) begin // R23
        s_nxt.rxSt = dctu_pkg::RX_START;
        s_nxt.rxSub = '0;
      end
      dctu_pkg::RX_START: if (tmEnd[0] && s_r.rxSub == dctu_pkg::SUB_MID) begin
        s_nxt.rxSt = serialInLine ? dctu_pkg::RX_IDLE : dctu_pkg::RX_DATA;
        s_nxt.rxSub = '0;
        s_nxt.rxBits = '0;
      end
      dctu_pkg::RX_DATA: if (tmEnd[0] && s_r.rxSub == dctu_pkg::SUB_LAST) begin
        s_nxt.rxShift = {serialInLine, s_r.rxShift[7:1]};
        s_nxt.rxBits = s_r.rxBits + 4'h1;
        if (s_r.rxBits == dctu_pkg::DATA_LAST) s_nxt.rxSt = dctu_pkg::RX_STOP; // R18
      end
      dctu_pkg::RX_STOP: if (tmEnd[0] && s_r.rxSub == dctu_pkg::SUB_LAST) begin
        s_nxt.rxSt = dctu_pkg::RX_IDLE;
        s_nxt.rxData = s_r.parEn ? {~^s_r.rxShift, s_r.rxShift[6:0]} : s_r.rxShift; // R19
        rxDone = 1'b1;
      end
    endcase
    // A character landing in the same cycle as the clearing read stays flagged.
    if (rxDone) s_nxt.rxFull = 1'b1;
    s_nxt.rxInt = s_r.serEn ? rxDone : serFall; // R20
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r <= '0;
      s_r.txLine <= 1'b1;
      s_r.tout <= 1'b0;
      s_r.tinPrev <= 1'b1;
      s_r.serPrev <= 1'b1;
      s_r.aPrev <= 1'b1;
      s_r.bPrev <= 1'b1;
      s_r.load0 <= dctu_pkg::LOAD_RST;
      s_r.load1 <= dctu_pkg::LOAD_RST;
      s_r.pre0 <= dctu_pkg::PRE_RST;
      s_r.pre1 <= dctu_pkg::PRE_RST;
      s_r.rxSt <= dctu_pkg::RX_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = s_r.awReady;
  assign s_axi_wready = s_r.wReady;
  assign s_axi_bvalid = s_r.bValid;
  assign s_axi_bresp = s_r.bResp;
  assign s_axi_arready = s_r.arReady;
  assign s_axi_rvalid = s_r.rValid;
  assign s_axi_rdata = s_r.rData;
  assign s_axi_rresp = s_r.rResp;
  assign serialOutLine = s_r.txLine;
  assign timerOutPin = s_r.tout;
  assign serialRxInterrupt = s_r.rxInt;
  assign serialTxOrFirstTimerInterrupt = s_r.txInt;
  assign secondTimerInterrupt = s_r.t1Int;
  assign extInterruptA = s_r.extA;
  assign extInterruptB = s_r.extB;
  assign extInterruptC = s_r.extC;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_div;
    s_r.divTick |=> !s_r.divTick [*3] ##1 s_r.divTick;
  endproperty
  a_div: assert property (p_div) else $error("internal divide by four broken"); // R9

  property p_t1Int;
    tmEnd[1] |=> secondTimerInterrupt;
  endproperty
  a_t1Int: assert property (p_t1Int) else $error("second timer request missing"); // R5

  property p_txStart;
    $rose(s_r.txBusy) |-> !serialOutLine ##1 !serialOutLine;
  endproperty
  a_txStart: assert property (p_txStart) else $error("start bit not driven"); // R15

  property p_txIdle;
    !s_r.txBusy |-> serialOutLine;
  endproperty
  a_txIdle: assert property (p_txIdle) else $error("transmit line not idle high"); // R23

  property p_txInt;
    $fell(s_r.txBusy) |-> serialTxOrFirstTimerInterrupt;
  endproperty
  a_txInt: assert property (p_txInt) else $error("transmit request missing"); // R17

  property p_parity;
    $rose(s_r.txBusy) && s_r.parEn |-> ^s_r.txShift[8:1];
  endproperty
  a_parity: assert property (p_parity) else $error("transmit parity not odd"); // R16

  property p_rxInt;
    $rose(s_r.rxFull) |-> serialRxInterrupt;
  endproperty
  a_rxInt: assert property (p_rxInt) else $error("receive request missing"); // R20

  property p_preHidden;
    s_axi_arvalid && s_axi_arready && rdAddr == dctu_pkg::OFF_FIRST_PRE |=> s_axi_rdata == 32'h0;
  endproperty
  a_preHidden: assert property (p_preHidden) else $error("prescaler readable"); // R8

  property p_extA;
    $fell(extLineA) |=> extInterruptA;
  endproperty
  a_extA: assert property (p_extA) else $error("external request a missing"); // R21

  c_txDone: cover property ($fell(s_r.txBusy));
  c_rxDone: cover property ($rose(s_r.rxFull));
  c_cascade: cover property (s_r.cascade && tmEnd[1]);
  c_trigger: cover property (trigger);
endmodule

// File: verif/dctu_remote.sv
/*
 * Remote asynchronous serial device: sends frames to the receiver and
 * captures frames from the transmitter.
 * Assumes a bit time of sixteen first-timer expiries with prescale 1, load 1.
 */
module dctu_remote (
  // Clock
  input wire logic clk_sys,
  // Serial lines
  input wire logic serialOutLine,
  output logic serialInLine
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT_CYC = 64;
  initial serialInLine = 1'b1;

  // A single stop bit is sent, the least the receiver must accept.
  task automatic sendFrame(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serialInLine <= f[i];
      repeat (BIT_CYC) @(posedge clk_sys);
    end
  endtask

  task automatic takeFrame(output logic [10:0] f);
    @(negedge serialOutLine);
    repeat (BIT_CYC / 2) @(posedge clk_sys);
    for (int i = 0; i < 11; i++) begin
      f[i] = serialOutLine;
      repeat (BIT_CYC) @(posedge clk_sys);
    end
  endtask
endmodule

// File: verif/dctu_top_bench.sv
/*
 * Self-checking bench for the counter/timer and serial block.
 * Assumes the remote serial model and a 10 MHz clock.
 */
module dctu_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, rst = 1'b1, serialIn, serialOut, timerIn = 1'b1, timerOut, lineA = 1'b1, lineB = 1'b1;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rxIrq, txIrq, t2Irq, extC, extAIrq, extBIrq;
  logic [1:0] bresp, rresp;
  int n_fail = 0, tests_run = 0, nTx = 0, nRx = 0, nT2 = 0, nEC = 0, nEA = 0, nEB = 0;

  dctu_top dctu_top_i (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .serialInLine(serialIn),
    .timerInPin(timerIn), .extLineA(lineA), .extLineB(lineB), .serialOutLine(serialOut),
    .timerOutPin(timerOut), .serialRxInterrupt(rxIrq), .serialTxOrFirstTimerInterrupt(txIrq),
    .secondTimerInterrupt(t2Irq), .extInterruptA(extAIrq), .extInterruptB(extBIrq), .extInterruptC(extC));
  dctu_remote dctu_remote_i (.clk_sys(clk_sys), .serialOutLine(serialOut), .serialInLine(serialIn));

  initial forever #50 clk_sys = ~clk_sys;

  always_ff @(posedge clk_sys) begin
    if (txIrq === 1'b1) nTx <= nTx + 1;
    if (rxIrq === 1'b1) nRx <= nRx + 1;
    if (t2Irq === 1'b1) nT2 <= nT2 + 1;
    if (extC === 1'b1) nEC <= nEC + 1;
    if (extAIrq === 1'b1) nEA <= nEA + 1;
    if (extBIrq === 1'b1) nEB <= nEB + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Each channel is released at the edge that takes it; a spare edge ends the task.
  task automatic axiWrite(input logic [4:0] a, input logic [7:0] d);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge clk_sys);
      if (!awDone && awready === 1'b1) begin
        awDone = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wDone && wready === 1'b1) begin
        wDone = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk_sys);
    chk({30'h0, bresp}, {30'h0, dctu_pkg::RESP_OKAY});
    bready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic axiRead(input logic [4:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (rvalid !== 1'b1);
    d = rdata;
    chk({30'h0, rresp}, {30'h0, dctu_pkg::RESP_OKAY});
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic test_regs;
    logic [31:0] d;
    axiRead(dctu_pkg::OFF_MODE, d);
    chk(d, {24'h0, dctu_pkg::MODE_RST});
    axiWrite(dctu_pkg::OFF_FIRST_PRE, 8'h05);
    axiRead(dctu_pkg::OFF_FIRST_PRE, d);
    chk(d, 32'h0);
    $display("test_regs done");
  endtask

  task automatic test_first;
    logic [31:0] d, e;
    int n, gap;
    axiWrite(dctu_pkg::OFF_FIRST_PRE, 8'h02);
    axiWrite(dctu_pkg::OFF_FIRST_CNT, 8'h03);
    n = nTx;
    axiWrite(dctu_pkg::OFF_CTRL, 8'h05);
    repeat (100) @(posedge clk_sys);
    chk(32'(nTx - n), 32'h1);
    chk({31'h0, timerOut}, 32'h1);
    axiRead(dctu_pkg::OFF_FIRST_CNT, d);
    chk(d, 32'h0);
    axiWrite(dctu_pkg::OFF_CTRL, 8'h07);
    n = nTx;
    while (nTx == n) @(posedge clk_sys);
    n = nTx;
    gap = 0;
    while (nTx == n) begin
      @(posedge clk_sys);
      gap++;
    end
    chk(32'(gap), 32'd24);
    axiWrite(dctu_pkg::OFF_CTRL, 8'h02);
    axiRead(dctu_pkg::OFF_FIRST_CNT, d);
    repeat (40) @(posedge clk_sys);
    axiRead(dctu_pkg::OFF_FIRST_CNT, e);
    chk(e, d);
    $display("test_first done");
  endtask

  task automatic test_second;
    int n, c, a, b;
    axiWrite(dctu_pkg::OFF_MODE, 8'h00);
    axiWrite(dctu_pkg::OFF_SECOND_PRE, 8'h01);
    axiWrite(dctu_pkg::OFF_SECOND_CNT, 8'h02);
    axiWrite(dctu_pkg::OFF_CTRL, 8'h28);
    n = nT2;
    c = nEC;
    a = nEA;
    b = nEB;
    repeat (2) begin
      timerIn <= 1'b0;
      lineA <= 1'b0;
      lineB <= 1'b0;
      repeat (3) @(posedge clk_sys);
      timerIn <= 1'b1;
      lineA <= 1'b1;
      lineB <= 1'b1;
      repeat (3) @(posedge clk_sys);
    end
    repeat (5) @(posedge clk_sys);
    chk(32'(nT2 - n), 32'h1);
    chk(32'(nEC - c), 32'h2);
    chk(32'(nEA - a), 32'h2);
    chk(32'(nEB - b), 32'h2);
    $display("test_second done");
  endtask

  // Transmit and receive run at once to show the port is full duplex.
  task automatic test_uart(input logic par, input logic [7:0] tx, input logic [7:0] rx);
    logic [10:0] f;
    logic [31:0] d;
    int n;
    axiWrite(dctu_pkg::OFF_FIRST_PRE, 8'h01);
    axiWrite(dctu_pkg::OFF_FIRST_CNT, 8'h01);
    axiWrite(dctu_pkg::OFF_CTRL, 8'h07);
    axiWrite(dctu_pkg::OFF_MODE, {1'b0, par, 6'h20});
    chk({31'h0, serialOut}, 32'h1);
    n = nRx;
    fork
      axiWrite(dctu_pkg::OFF_SER_DATA, tx);
      dctu_remote_i.takeFrame(f);
      dctu_remote_i.sendFrame(rx);
    join
    repeat (10) @(posedge clk_sys);
    chk({29'h0, f[10:9], f[0]}, 32'h6);
    chk({24'h0, f[8:1]}, {24'h0, par ? {~^tx[6:0], tx[6:0]} : tx});
    chk(32'(nRx - n), 32'h1);
    axiRead(dctu_pkg::OFF_SER_DATA, d);
    chk(d, {24'h0, par ? {~^rx, rx[6:0]} : rx});
    $display("test_uart done");
  endtask

  initial begin
    #5_000_000;
    n_fail++;
    complete_run;
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    test_regs;
    test_first;
    test_second;
    test_uart(1'b0, 8'h35, 8'hc6);
    test_uart(1'b1, 8'ha5, 8'h03);
    complete_run;
  end
endmodule
